// *** verilog/fetch_addr_map.vh ***
// register indices, field positions, reset values and codes of the fetch address generator
`ifndef FETCH_ADDR_MAP_VH
`define FETCH_ADDR_MAP_VH

// ----------------------------------------------------------------
// register indices (byte address = 4 x index)
// ----------------------------------------------------------------
`define IDX_S1_LOW 6'h0c
`define IDX_S1_MID 6'h0d
`define IDX_S2_LOW 6'h0e
`define IDX_S2_HIGH 6'h0f
`define IDX_S1_TOP 6'h10
`define IDX_LINE_OFS 6'h11
`define IDX_VSIZE_LOW 6'h12
`define IDX_VSIZE_HIGH 6'h13
`define IDX_CTRL 6'h20
`define IDX_WIDTH 6'h21
`define IDX_LINES 6'h22
`define IDX_STATUS 6'h23

// ----------------------------------------------------------------
// byte address decode
// ----------------------------------------------------------------
`define ADDR_IDX_HI 7
`define ADDR_IDX_LO 2

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define CTRL_ENABLE 0
`define CTRL_PORTRAIT 1
`define CTRL_BPP_HI 3
`define CTRL_BPP_LO 2

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define ST_SECOND 10
`define ST_RUN 11
`define ST_STEP_LO 16
`define ST_PPB_LO 24

// ----------------------------------------------------------------
// widths, reset values and pixel counts
// ----------------------------------------------------------------
`define TOP_BIT 0
`define VSIZE_HIGH_W 2
`define RST_BYTE 8'h00
`define RST_VSIZE 10'h3ff
`define RST_VSIZE_LOW 8'hff
`define RST_VSIZE_HIGH 2'h3
`define PIX_PER_WORD 5'h10
`define PIX_PER_BYTE 5'h08

// ----------------------------------------------------------------
// axi responses
// ----------------------------------------------------------------
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// *** verilog/fetch_fifo.v ***
// synchronous fifo carrying fetch line addresses to the refresh fetch
`timescale 1ns/1ps
`default_nettype none

module fetch_fifo #(
  parameter WIDTH = 19,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire aclk,
  input wire aresetn,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage array
  reg [AW-1:0] wr_q; // write pointer
  reg [AW-1:0] rd_q; // read pointer
  reg [AW:0] cnt_q; // fill level
  wire push; // word accepted
  wire pop; // word delivered

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_q];

  // storage write, no reset needed
  always @(posedge aclk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // pointers and level
  always @(posedge aclk) begin
    if (!aresetn) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule // fetch_fifo

`default_nettype wire

// *** verilog/display_fetch_address_gen.v ***
// frame buffer fetch address generator with axi4-lite registers
// Notes on behaviour
// - three byte registers form 17-bit start
// - landscape start is a word offset
// - landscape step moves one word of pixels
// - pixels packed per byte by colour depth
// - portrait start is a byte offset
// - portrait pan step half the landscape step
// - frame begins with first image start, or with second start when split at line 0
// - lower image fetched from second start
// - second image begins at vertical size line
// - split may fall on any line
// - line advance by visible plus extra words
// - 8-bit offset gives extra words per line
// - vertical size is 10 bits, two registers
// - size at or past panel hides second
// - portrait never uses the second image
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fetch_addr_map.vh"

module display_fetch_address_gen #(
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW = 5,
  parameter [9:0] DEFAULT_LINES = 10'd240,
  parameter [7:0] DEFAULT_WIDTH = 8'd20
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output wire fetch_valid,
  input wire fetch_ready,
  output wire [17:0] fetch_addr,
  output wire fetch_second
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // memory byte address from a start value
  function [17:0] to_byte;
    input [16:0] start;
    input portrait;
    begin
      if (portrait) begin
        to_byte = {1'b0, start};
      end else begin
        to_byte = {start, 1'b0};
      end
    end
  endfunction

  // pixels moved by one start step
  function [4:0] pan_step;
    input [1:0] bpp;
    input portrait;
    begin
      if (portrait) begin
        pan_step = `PIX_PER_BYTE >> bpp;
      end else begin
        pan_step = `PIX_PER_WORD >> bpp;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0] s1_low_q; // first start bits 7:0
  reg [7:0] s1_mid_q; // first start bits 15:8
  reg s1_top_q; // first start bit 16
  reg [7:0] s2_low_q; // second start bits 7:0
  reg [7:0] s2_high_q; // second start bits 15:8
  reg [7:0] line_ofs_q; // extra words per line
  reg [7:0] vsize_low_q; // vertical size bits 7:0
  reg [1:0] vsize_high_q; // vertical size bits 9:8
  reg [3:0] ctrl_q; // enable, portrait, depth
  reg [7:0] width_q; // visible words per line
  reg [9:0] lines_q; // physical panel lines
  wire [16:0] s1_live; // assembled first start
  wire [16:0] s2_live; // assembled second start
  wire [9:0] vsize_live; // assembled vertical size
  wire [8:0] stride_live; // words per virtual line

  assign s1_live = {s1_top_q, s1_mid_q, s1_low_q};
  assign s2_live = {1'b0, s2_high_q, s2_low_q};
  assign vsize_live = {vsize_high_q, vsize_low_q};
  assign stride_live = {1'b0, width_q} + {1'b0, line_ofs_q};

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  reg aw_have_q; // address held
  reg w_have_q; // data held
  reg [5:0] aw_idx_q; // held register index
  reg [7:0] w_byte_q; // held low byte
  reg [31:0] w_word_q; // held full word
  reg w_lane0_q; // low byte lane enabled
  reg bvalid_q; // write answer pending
  reg [1:0] bresp_q; // write answer code
  wire do_write; // both halves present
  reg wr_ok; // index is writable

  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign do_write = aw_have_q & w_have_q & !bvalid_q;

  // writable decode
  always @* begin
    case (aw_idx_q)
      `IDX_S1_LOW, `IDX_S1_MID, `IDX_S1_TOP, `IDX_S2_LOW, `IDX_S2_HIGH: begin
        wr_ok = 1'b1;
      end
      `IDX_LINE_OFS, `IDX_VSIZE_LOW, `IDX_VSIZE_HIGH: begin
        wr_ok = 1'b1;
      end
      `IDX_CTRL, `IDX_WIDTH, `IDX_LINES: begin
        wr_ok = 1'b1;
      end
      default: begin
        wr_ok = 1'b0;
      end
    endcase
  end

  // address and data capture, answer
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_idx_q <= 6'h00;
      w_byte_q <= `RST_BYTE;
      w_word_q <= 32'h0000_0000;
      w_lane0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else begin
      // take address
      if (s_axi_awvalid && !aw_have_q) begin
        aw_have_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr[`ADDR_IDX_HI:`ADDR_IDX_LO];
      end
      // take data
      if (s_axi_wvalid && !w_have_q) begin
        w_have_q <= 1'b1;
        w_byte_q <= s_axi_wdata[7:0];
        w_word_q <= s_axi_wdata;
        w_lane0_q <= s_axi_wstrb[0];
      end
      // complete write
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // register file update
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_low_q <= `RST_BYTE;
      s1_mid_q <= `RST_BYTE;
      s1_top_q <= 1'b0;
      s2_low_q <= `RST_BYTE;
      s2_high_q <= `RST_BYTE;
      line_ofs_q <= `RST_BYTE;
      vsize_low_q <= `RST_VSIZE_LOW;
      vsize_high_q <= `RST_VSIZE_HIGH;
      ctrl_q <= 4'h0;
      width_q <= DEFAULT_WIDTH;
      lines_q <= DEFAULT_LINES;
    end else if (do_write && w_lane0_q) begin
      case (aw_idx_q)
        `IDX_S1_LOW: begin
          s1_low_q <= w_byte_q;
        end
        `IDX_S1_MID: begin
          s1_mid_q <= w_byte_q;
        end
        `IDX_S1_TOP: begin
          s1_top_q <= w_byte_q[`TOP_BIT];
        end
        `IDX_S2_LOW: begin
          s2_low_q <= w_byte_q;
        end
        `IDX_S2_HIGH: begin
          s2_high_q <= w_byte_q;
        end
        `IDX_LINE_OFS: begin
          line_ofs_q <= w_byte_q;
        end
        `IDX_VSIZE_LOW: begin
          vsize_low_q <= w_byte_q;
        end
        `IDX_VSIZE_HIGH: begin
          vsize_high_q <= w_byte_q[`VSIZE_HIGH_W-1:0];
        end
        `IDX_CTRL: begin
          ctrl_q <= w_byte_q[3:0];
        end
        `IDX_WIDTH: begin
          width_q <= w_byte_q;
        end
        `IDX_LINES: begin
          lines_q <= w_word_q[9:0];
        end
        default: begin
          ctrl_q <= ctrl_q; // unmapped, nothing stored
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // line address generator
  // ----------------------------------------------------------------
  reg run_q; // generator active
  reg [9:0] line_q; // line being queued
  reg [17:0] addr_q; // byte address of that line
  reg second_q; // line belongs to second image
  reg portrait_sh_q; // frame copy of orientation
  reg [16:0] s2_sh_q; // frame copy of second start
  reg [9:0] vsize_sh_q; // frame copy of vertical size
  reg [9:0] lines_sh_q; // frame copy of panel lines
  reg [8:0] stride_sh_q; // frame copy of stride
  wire gen_ready; // fifo can take a line
  wire push; // line handed to fifo
  wire split_live; // split allowed with live settings
  wire split_sh; // split allowed this frame
  wire last_line; // final panel line queued
  wire [9:0] line_nx; // following line number

  // split needs landscape and a size short of the panel
  assign split_live = !ctrl_q[`CTRL_PORTRAIT] && (vsize_live < lines_q);
  assign split_sh = !portrait_sh_q && (vsize_sh_q < lines_sh_q);
  assign push = run_q & gen_ready;
  assign last_line = (line_q == lines_sh_q - 10'd1);
  assign line_nx = line_q + 10'd1;

  // frame sequencing and address stepping
  always @(posedge aclk) begin
    if (!aresetn) begin
      run_q <= 1'b0;
      line_q <= 10'h000;
      addr_q <= 18'h00000;
      second_q <= 1'b0;
      portrait_sh_q <= 1'b0;
      s2_sh_q <= 17'h00000;
      vsize_sh_q <= `RST_VSIZE;
      lines_sh_q <= DEFAULT_LINES;
      stride_sh_q <= 9'h000;
    end else if ((!run_q || (push && last_line)) && ctrl_q[`CTRL_ENABLE]) begin
      // frame start: copy settings, begin at first image, or at second when split at line 0
      run_q <= 1'b1;
      line_q <= 10'h000;
      portrait_sh_q <= ctrl_q[`CTRL_PORTRAIT];
      s2_sh_q <= s2_live;
      vsize_sh_q <= vsize_live;
      lines_sh_q <= lines_q;
      stride_sh_q <= stride_live;
      if (split_live && vsize_live == 10'h000) begin
        addr_q <= to_byte(s2_live, 1'b0);
        second_q <= 1'b1;
      end else begin
        addr_q <= to_byte(s1_live, ctrl_q[`CTRL_PORTRAIT]);
        second_q <= 1'b0;
      end
    end else if (push && last_line) begin
      // frame ends with generator disabled
      run_q <= 1'b0;
    end else if (push) begin
      line_q <= line_nx;
      if (split_sh && line_nx == vsize_sh_q) begin
        addr_q <= to_byte(s2_sh_q, 1'b0);
        second_q <= 1'b1;
      end else begin
        addr_q <= addr_q + {8'h00, stride_sh_q, 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // fifo toward the refresh fetch
  // ----------------------------------------------------------------
  fetch_fifo #(
    .WIDTH(19),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(run_q),
    .in_ready(gen_ready),
    .in_data({second_q, addr_q}),
    .out_valid(fetch_valid),
    .out_ready(fetch_ready),
    .out_data({fetch_second, fetch_addr})
  );

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  reg rvalid_q; // read answer pending
  reg [31:0] rdata_q; // read answer data
  reg [1:0] rresp_q; // read answer code
  reg [31:0] rd_mux; // decoded read value
  reg rd_ok; // index is mapped
  wire [5:0] ar_idx; // requested index

  assign ar_idx = s_axi_araddr[`ADDR_IDX_HI:`ADDR_IDX_LO];
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // read decode, status shows generator state
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    case (ar_idx)
      `IDX_S1_LOW: rd_mux[7:0] = s1_low_q;
      `IDX_S1_MID: rd_mux[7:0] = s1_mid_q;
      `IDX_S1_TOP: rd_mux[0] = s1_top_q;
      `IDX_S2_LOW: rd_mux[7:0] = s2_low_q;
      `IDX_S2_HIGH: rd_mux[7:0] = s2_high_q;
      `IDX_LINE_OFS: rd_mux[7:0] = line_ofs_q;
      `IDX_VSIZE_LOW: rd_mux[7:0] = vsize_low_q;
      `IDX_VSIZE_HIGH: rd_mux[1:0] = vsize_high_q;
      `IDX_CTRL: rd_mux[3:0] = ctrl_q;
      `IDX_WIDTH: rd_mux[7:0] = width_q;
      `IDX_LINES: rd_mux[9:0] = lines_q;
      `IDX_STATUS: begin
        rd_mux[9:0] = line_q;
        rd_mux[`ST_SECOND] = second_q;
        rd_mux[`ST_RUN] = run_q;
        rd_mux[`ST_STEP_LO+4:`ST_STEP_LO] =
          pan_step(ctrl_q[`CTRL_BPP_HI:`CTRL_BPP_LO], ctrl_q[`CTRL_PORTRAIT]);
        rd_mux[`ST_PPB_LO+4:`ST_PPB_LO] =
          pan_step(ctrl_q[`CTRL_BPP_HI:`CTRL_BPP_LO], 1'b1);
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // read answer register
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule // display_fetch_address_gen

`default_nettype wire

// *** tb/fetch_gen_checker_assertions.sv ***
// concurrent checks on the fetch address generator ports
`timescale 1ns/1ps
`default_nettype none
`include "fetch_addr_map.vh"

module fetch_gen_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic fetch_valid,
  input wire logic fetch_ready,
  input wire logic [17:0] fetch_addr,
  input wire logic fetch_second
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // read index and whether it names a register
  wire logic [5:0] ridx = s_axi_araddr[7:2];
  wire logic hole = !((ridx >= `IDX_S1_LOW && ridx <= `IDX_VSIZE_HIGH) ||
    (ridx >= `IDX_CTRL && ridx <= `IDX_STATUS));
  a_ready_reset: assert property ($rose(aresetn) |-> s_axi_awready && s_axi_wready &&
    s_axi_arready && !fetch_valid && !s_axi_bvalid) else $error("idle state after reset");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write answer missing");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_read_okay: assert property (s_axi_arvalid && s_axi_arready && !hole |=>
    s_axi_rvalid && s_axi_rresp == `RESP_OKAY) else $error("read answer wrong");
  a_read_hole: assert property (s_axi_arvalid && s_axi_arready && hole |=> s_axi_rvalid &&
    s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0) else $error("hole read answer wrong");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
    $stable(s_axi_rdata)) else $error("read data dropped");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken");
  a_fetch_hold: assert property (fetch_valid && !fetch_ready |=> fetch_valid &&
    $stable(fetch_addr) && $stable(fetch_second)) else $error("line entry changed");
endmodule // fetch_gen_checker

bind display_fetch_address_gen fetch_gen_checker u_chk (.aclk, .aresetn, .s_axi_araddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .fetch_valid, .fetch_ready, .fetch_addr, .fetch_second);
`default_nettype wire

// *** tb/refresh_fetch_model.sv ***
// model of the refresh fetch that takes queued line addresses
`timescale 1ns/1ps
`default_nettype none

module refresh_fetch_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] pace, // 0 prompt, 1 slow random, 2 stalled
  output logic fetch_ready
);
  integer seed = 32'habb85b7e; // fixed seed, repeatable stalls
  // ready moves only just after an edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      fetch_ready <= 1'b0;
    end else begin
      fetch_ready <= (pace == 2'd0) || (pace == 2'd1 && ($random(seed) & 3) == 0);
    end
  end
endmodule // refresh_fetch_model
`default_nettype wire

// *** tb/display_fetch_address_gen_tb.sv ***
// self-checking bench of the fetch address generator
`timescale 1ns/1ps
`default_nettype none
`include "fetch_addr_map.vh"

module display_fetch_address_gen_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [1:0] pace = 2'd0; // consumer speed
  wire logic awready, wready, bvalid, arready, rvalid, fetch_valid, fetch_ready, fetch_second;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [17:0] fetch_addr;
  integer seed = 32'habb85b7e;
  int err_total = 0, checks = 0, pop_n = 0;
  int c_cut = 0; // first pop that sees the mid-frame width
  // software view of the current settings
  logic [16:0] c_s1;
  logic [15:0] c_s2;
  logic [7:0] c_w, c_o;
  logic [7:0] c_w2; // width written while the queue is full
  logic [9:0] c_v, c_l;
  logic c_p;
  logic [1:0] c_bpp;
  logic [31:0] rd; // last answer data
  logic [1:0] rsp; // last answer code

  always #20 aclk = ~aclk;

  display_fetch_address_gen u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'b000), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'b000), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fetch_valid(fetch_valid),
    .fetch_ready(fetch_ready), .fetch_addr(fetch_addr), .fetch_second(fetch_second));

  refresh_fetch_model u_fetch (.aclk(aclk), .aresetn(aresetn), .pace(pace),
    .fetch_ready(fetch_ready));

  // ----------------------------------------------------------------
  // expectation and reporting
  // ----------------------------------------------------------------
  function automatic bit exp_sec(input int i);
    return !c_p && c_v < c_l && i >= c_v;
  endfunction

  function automatic logic [17:0] exp_addr(input int i, input bit late);
    int st;
    st = 2 * (int'(late ? c_w2 : c_w) + int'(c_o));
    if (exp_sec(i)) return 18'(2 * int'(c_s2) + (i - int'(c_v)) * st);
    return 18'((c_p ? int'(c_s1) : 2 * int'(c_s1)) + i * st);
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic timed_out(input string what);
    err_total++;
    $display("ERROR %s expected handshake seen none", what);
    report_and_stop();
  endtask

  // ----------------------------------------------------------------
  // register bus master
  // ----------------------------------------------------------------
  // ready stands until the answer is seen at a rising edge
  task automatic take_answer(input bit is_rd);
    int n;
    rready <= is_rd;
    bready <= !is_rd;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!(is_rd ? rvalid : bvalid) && n < 40);
    if (!(is_rd ? rvalid : bvalid)) timed_out("answer");
    rd = rdata;
    rsp = is_rd ? rresp : bresp;
    rready <= 1'b0;
    bready <= 1'b0;
  endtask

  task automatic axi_wr(input logic [5:0] idx, input logic [31:0] d, input logic [3:0] st);
    logic pa, pw, ta, tw;
    int n;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    for (n = 0; n < 40 && (pa || pw); n++) begin
      @(negedge aclk);
      ta = pa && awready;
      tw = pw && wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    if (pa || pw) timed_out("write accept");
    take_answer(1'b0);
  endtask

  task automatic axi_rd(input logic [5:0] idx);
    int n;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (!arready && n < 40);
    if (!arready) timed_out("read accept");
    @(posedge aclk);
    arvalid <= 1'b0;
    take_answer(1'b1);
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp, input string what);
    axi_rd(idx);
    check(what, rd, exp);
  endtask

  // every popped line entry against the expected frame walk
  always @(posedge aclk) begin
    if (aresetn && fetch_valid && fetch_ready) begin
      check("line addr", 32'(fetch_addr), 32'(exp_addr(pop_n % c_l, pop_n >= c_cut)));
      check("line image", 32'(fetch_second), 32'(exp_sec(pop_n % c_l)));
      pop_n++;
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int k, n, q;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(`IDX_S1_LOW, 32'h0, "start low reset");
    rd_chk(`IDX_LINE_OFS, 32'h0, "offset reset");
    rd_chk(`IDX_VSIZE_LOW, 32'hff, "vsize low reset");
    rd_chk(`IDX_CTRL, 32'h0, "ctrl reset");
    rd_chk(`IDX_WIDTH, 32'h14, "width reset");
    rd_chk(`IDX_LINES, 32'hf0, "lines reset");
    axi_wr(`IDX_S1_TOP, 32'hffffffff, 4'hf);
    rd_chk(`IDX_S1_TOP, 32'h1, "start top bits");
    axi_wr(`IDX_VSIZE_HIGH, 32'hff, 4'hf);
    rd_chk(`IDX_VSIZE_HIGH, 32'h3, "vsize high bits");
    axi_wr(`IDX_LINE_OFS, 32'h5a, 4'h0);
    rd_chk(`IDX_LINE_OFS, 32'h0, "offset no strobe");
    axi_wr(6'h3f, 32'h1, 4'hf);
    check("hole write code", 32'(rsp), 32'(`RESP_SLVERR));
    rd_chk(6'h3f, 32'h0, "hole read data");
    check("hole read code", 32'(rsp), 32'(`RESP_SLVERR));
    $display("test register map done");
    for (k = 0; k < 8; k++) begin
      c_p = k[2];
      c_bpp = k[1:0];
      // scroll down one virtual line after the first setup
      c_s1 = (k == 0) ? 17'($random(seed)) & 17'h100ff : c_s1 + 17'(c_w) + 17'(c_o);
      c_s2 = 16'($random(seed));
      c_l = 10'd4 + 10'($unsigned($random(seed)) % 9);
      c_w = 8'($unsigned($random(seed)) % 64);
      c_o = 8'($random(seed));
      c_v = (k == 1) ? c_l : (k == 2) ? 10'd0 : (k == 3) ? c_l - 10'd1 :
        10'($unsigned($random(seed)) % c_l);
      c_w2 = c_w;
      c_cut = 32'h7fffffff;
      axi_wr(`IDX_S1_LOW, 32'(c_s1[7:0]), 4'hf);
      axi_wr(`IDX_S1_MID, 32'(c_s1[15:8]), 4'hf);
      axi_wr(`IDX_S1_TOP, {31'($random(seed)), c_s1[16]}, 4'hf);
      axi_wr(`IDX_S2_LOW, 32'(c_s2[7:0]), 4'hf);
      axi_wr(`IDX_S2_HIGH, 32'(c_s2[15:8]), 4'hf);
      axi_wr(`IDX_LINE_OFS, 32'(c_o), 4'hf);
      axi_wr(`IDX_VSIZE_LOW, 32'(c_v[7:0]), 4'hf);
      axi_wr(`IDX_VSIZE_HIGH, {30'($random(seed)), c_v[9:8]}, 4'hf);
      axi_wr(`IDX_WIDTH, 32'(c_w), 4'hf);
      axi_wr(`IDX_LINES, 32'(c_l), 4'hf);
      pace <= 2'(k % 3);
      axi_wr(`IDX_CTRL, {28'h0, c_bpp, c_p, 1'b1}, 4'hf);
      axi_rd(`IDX_STATUS);
      check("pan step", 32'(rd[20:16]), c_p ? 32'(8 >> c_bpp) : 32'(16 >> c_bpp));
      check("pixels per byte", 32'(rd[28:24]), 32'(8 >> c_bpp));
      // stalled consumer lets the queue fill before draining
      n = 0;
      while (pop_n < 2 * c_l && n < 3000) begin
        @(posedge aclk);
        n++;
        // full queue holds the generator mid-frame: new width from the next frame on
        if (n == 40 && pace == 2'd2) begin
          c_w2 = c_w + 8'd1;
          c_cut = (32 / int'(c_l) + 1) * int'(c_l);
          axi_wr(`IDX_WIDTH, 32'(c_w2), 4'hf);
        end
        if (n == 60) pace <= 2'd1;
      end
      if (n >= 3000) timed_out("frame lines");
      axi_wr(`IDX_CTRL, {28'h0, c_bpp, c_p, 1'b0}, 4'hf);
      q = 0;
      for (n = 0; q < 40 && n < 3000; n++) begin
        @(negedge aclk);
        q = fetch_valid ? 0 : q + 1;
      end
      if (q < 40) timed_out("drain");
      check("whole frames", 32'(pop_n % c_l), 32'h0);
      pop_n = 0;
      $display("test frame setup %0d done", k);
    end
    report_and_stop();
  end
endmodule // display_fetch_address_gen_tb
`default_nettype wire
